// *** inc/srw_pkg.sv ***
// Package of constants for the supervisor reset watchdog
package srw_pkg;

  // ****************************************************************
  // Clock
  // ****************************************************************
  localparam int unsigned CLK_HZ = 40000000;

  // ****************************************************************
  // Reset hold time choices, in microseconds
  // ****************************************************************
  localparam int unsigned HOLD_D1_US = 1400;
  localparam int unsigned HOLD_D2_US = 28000;
  localparam int unsigned HOLD_D3_US = 200000;
  localparam int unsigned HOLD_D4_US = 600000;

  // ****************************************************************
  // Watchdog period choices, in microseconds
  // ****************************************************************
  localparam int unsigned WDOG_W1_US = 6200;
  localparam int unsigned WDOG_W2_US = 102000;
  localparam int unsigned WDOG_W3_US = 1600000;
  localparam int unsigned WDOG_W4_US = 25600000;

  // ****************************************************************
  // Build-time selection codes
  // ****************************************************************
  localparam logic [1:0] SEL_1 = 2'h0;
  localparam logic [1:0] SEL_2 = 2'h1;
  localparam logic [1:0] SEL_3 = 2'h2;
  localparam logic [1:0] SEL_4 = 2'h3;

  // Cycles per microsecond at the clock rate
  localparam longint unsigned CYC_PER_US = CLK_HZ / 1000000;

  // Reset hold counter width fits the longest choice
  localparam int unsigned CNT_W = 40;

  localparam logic [CNT_W-1:0] CNT_ZERO = 40'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 40'h1;

  typedef enum logic [1:0] {SRW_RUN, SRW_HOLD} srw_state_t;

endpackage

// *** design/srw_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module srw_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] rst_val_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // First stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= rst_val_i;
      q_o    <= rst_val_i;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

// *** design/srw_top.sv ***
// Supervisor: reset merge and stretch, watchdog, power flags
`timescale 1ns/1ps
module srw_top
  import srw_pkg::*;
#(
  parameter logic [1:0]  HOLD_SEL   = SEL_3,
  parameter logic [1:0]  WDOG_SEL   = SEL_3,
  parameter bit          ACT_HIGH   = 1'b0,
  parameter longint unsigned HOLD_CYC_OVR = 0,
  parameter longint unsigned WDOG_CYC_OVR = 0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic manual_reset_n_i,
  input  wire logic supply_low_i,
  input  wire logic below_early_warning_level_i,
  input  wire logic power_fail_sense_in_i,
  input  wire logic watchdog_activity_in_i,
  output logic      reset_n_o,
  output logic      reset_o,
  output logic      power_fail_flag_n_o,
  output logic      supply_low_warning_n_o
);

  // ****************************************************************
  // Period selection
  // ****************************************************************
  function automatic longint unsigned pick_us(
    input logic [1:0]  sel,
    input int unsigned a,
    input int unsigned b,
    input int unsigned c,
    input int unsigned d
  );
    case (sel)
      SEL_1:   pick_us = a;
      SEL_2:   pick_us = b;
      SEL_3:   pick_us = c;
      default: pick_us = d;
    endcase
  endfunction

  localparam longint unsigned HOLD_CYC = (HOLD_CYC_OVR != 0) ?
    HOLD_CYC_OVR : CYC_PER_US * pick_us(HOLD_SEL, HOLD_D1_US,
    HOLD_D2_US, HOLD_D3_US, HOLD_D4_US);
  localparam longint unsigned WDOG_CYC = (WDOG_CYC_OVR != 0) ?
    WDOG_CYC_OVR : CYC_PER_US * pick_us(WDOG_SEL, WDOG_W1_US,
    WDOG_W2_US, WDOG_W3_US, WDOG_W4_US);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WDOG_CYC - 1);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [4:0] pins_s;
  logic       mr_n_s;
  logic       slow_s;
  logic       early_s;
  logic       pf_s;
  logic       act_s;

  srw_sync #(.W(5)) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rst_val_i (5'h01),
    .d_i       ({watchdog_activity_in_i, power_fail_sense_in_i,
                 below_early_warning_level_i, supply_low_i,
                 manual_reset_n_i}),
    .q_o       (pins_s)
  );
  assign {act_s, pf_s, early_s, slow_s, mr_n_s} = pins_s;

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  logic             act_d_r;
  logic             act_edge;
  logic [CNT_W-1:0] wd_cnt_r;
  logic             wd_trip;
  srw_state_t       state_r;
  logic [CNT_W-1:0] hold_cnt_r;
  logic             cause;
  logic             hold_done;

  assign act_edge = act_s ^ act_d_r;
  assign wd_trip  = (state_r == SRW_RUN) && (wd_cnt_r == WDOG_LAST) &&
                    !act_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_d_r <= 1'b0;
    end else begin
      act_d_r <= act_s;
    end
  end

  // Restart on edge or pulse end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt_r <= CNT_ZERO;
    end else if (state_r != SRW_RUN || act_edge || wd_trip) begin
      wd_cnt_r <= CNT_ZERO;
    end else begin
      wd_cnt_r <= wd_cnt_r + CNT_ONE;
    end
  end

  // ****************************************************************
  // Reset stretch
  // ****************************************************************
  // Live causes hold reset
  assign cause     = !mr_n_s || slow_s;
  assign hold_done = (hold_cnt_r == HOLD_LAST);

  // Block wakes up in reset so the processor starts clean
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= SRW_HOLD;
      hold_cnt_r <= CNT_ZERO;
    end else begin
      case (state_r)
        SRW_RUN: begin
          hold_cnt_r <= CNT_ZERO;
          if (cause || wd_trip) begin
            state_r <= SRW_HOLD;
          end
        end
        SRW_HOLD: begin
          // Count restarts while a cause is live
          if (cause) begin
            hold_cnt_r <= CNT_ZERO;
          end else if (hold_done) begin
            state_r <= SRW_RUN;
          end else begin
            hold_cnt_r <= hold_cnt_r + CNT_ONE;
          end
        end
        default: begin
          state_r    <= SRW_HOLD;
          hold_cnt_r <= CNT_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic rst_nxt;
  assign rst_nxt = (state_r == SRW_HOLD && !(hold_done && !cause)) ||
                   (state_r == SRW_RUN && (cause || wd_trip));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_n_o <= 1'b0;
      reset_o   <= 1'b1;
    end else begin
      reset_n_o <= !rst_nxt;
      reset_o   <= ACT_HIGH ? rst_nxt : 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_fail_flag_n_o    <= 1'b1;
      supply_low_warning_n_o <= 1'b1;
    end else begin
      power_fail_flag_n_o    <= !pf_s;
      supply_low_warning_n_o <= !(early_s || slow_s);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Assertion helper: cycles the current reset pulse has lasted
  logic [CNT_W-1:0] low_cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_n_o) begin
      low_cnt_r <= CNT_ZERO;
    end else begin
      low_cnt_r <= low_cnt_r + CNT_ONE;
    end
  end

  // A live cause keeps reset low on the next two samples
  sequence s_held_low;
    !reset_n_o ##1 !reset_n_o;
  endsequence

  a_manual_holds: assert property (
    @(posedge clk_i) disable iff (rst_i) !mr_n_s |=> !reset_n_o)
    else $error("manual reset not held");
  a_pulse_min: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(reset_n_o) |-> low_cnt_r > HOLD_LAST)
    else $error("reset pulse too short");
  a_supply_holds: assert property (
    @(posedge clk_i) disable iff (rst_i) slow_s |=> !reset_n_o)
    else $error("supply low not held");
  a_release_clear: assert property (
    @(posedge clk_i) disable iff (rst_i) cause |=> s_held_low)
    else $error("release with cause live");
  a_variant_compl: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ACT_HIGH |-> (reset_o == !reset_n_o))
    else $error("variant not complement");
  a_pf_flag: assert property (
    @(posedge clk_i) disable iff (rst_i) pf_s |=> !power_fail_flag_n_o)
    else $error("power flag wrong");
  a_low_line: assert property (
    @(posedge clk_i) disable iff (rst_i)
    early_s |=> !supply_low_warning_n_o)
    else $error("warning missing");
  a_wd_trip: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wd_trip |=> !reset_n_o && wd_cnt_r == CNT_ZERO)
    else $error("watchdog did not reset");
  a_wd_restart: assert property (
    @(posedge clk_i) disable iff (rst_i)
    act_edge |=> wd_cnt_r == CNT_ZERO)
    else $error("watchdog not restarted");

endmodule

// *** tb/srw_cpu_model.sv ***
// Processor model that strobes the watchdog activity line
`timescale 1ns/1ps
module srw_cpu_model #(
  parameter int unsigned GAP = 20
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic run_i,
  output logic      activity_o
);
  int unsigned cnt_r;
  logic        act_r = 1'b0;

  // ****************************************************************
  // Activity strobe
  // ****************************************************************
  // Stalled firmware is modelled by dropping run_i, line then freezes
  // toggle within period
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !run_i) begin
      cnt_r <= 0;
    end else if (cnt_r == GAP - 1) begin
      cnt_r <= 0;
      act_r <= ~act_r;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end

  assign activity_o = act_r;
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the supervisor block
`timescale 1ns/1ps
module tb_top;
  import srw_pkg::*;
  // Short counts keep the run brief
  localparam int unsigned HOLD = 16;
  localparam int unsigned WDOG = 64;
  logic clk_i, rst_i, manual_reset_n_i, supply_low_i, early_i, pf_i;
  logic run, act, reset_n_o, reset_o, pf_n_o, ll_n_o;
  int   errors, checks, n;

  srw_top #(.HOLD_CYC_OVR(HOLD), .WDOG_CYC_OVR(WDOG),
            .ACT_HIGH(1'b1)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .manual_reset_n_i(manual_reset_n_i),
    .supply_low_i(supply_low_i), .below_early_warning_level_i(early_i),
    .power_fail_sense_in_i(pf_i), .watchdog_activity_in_i(act),
    .reset_n_o(reset_n_o), .reset_o(reset_o),
    .power_fail_flag_n_o(pf_n_o), .supply_low_warning_n_o(ll_n_o));

  srw_cpu_model #(.GAP(20)) cpu (
    .clk_i(clk_i), .reset_n_i(reset_n_o), .run_i(run), .activity_o(act));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Bounded wait for reset_n_o to reach v, cycles in cnt
  task automatic wait_rst(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (reset_n_o !== v && cnt < lim) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_flags();
    @(posedge clk_i) pf_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    chk("power fail flag", 1'b0, pf_n_o);
    chk("low line idle", 1'b1, ll_n_o);
    @(posedge clk_i) early_i <= 1'b1;
    pf_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk("low line warn", 1'b0, ll_n_o);
    chk("power fail clear", 1'b1, pf_n_o);
    chk("warn before reset", 1'b1, reset_n_o);
    @(posedge clk_i) early_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk("low line clear", 1'b1, ll_n_o);
  endtask

  task automatic t_manual();
    @(posedge clk_i) manual_reset_n_i <= 1'b0;
    wait_rst(1'b0, 8, n);
    repeat (40) begin
      @(posedge clk_i);
      #1;
      chk("manual held", 1'b0, reset_n_o);
      chk("reset_o high", 1'b1, reset_o);
    end
    @(posedge clk_i) manual_reset_n_i <= 1'b1;
    wait_rst(1'b1, HOLD + 10, n);
    chk("hold after manual", 1'b1, n >= HOLD);
    chk("manual released", 1'b1, reset_n_o);
    chk("reset_o low", 1'b0, reset_o);
  endtask

  // Two-cycle supply dip must still give a full pulse
  task automatic t_supply();
    @(posedge clk_i) supply_low_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    supply_low_i <= 1'b0;
    wait_rst(1'b0, 8, n);
    chk("dip asserts", 1'b0, reset_n_o);
    chk("low line on dip", 1'b0, ll_n_o);
    wait_rst(1'b1, HOLD + 10, n);
    chk("dip stretched", 1'b1, n >= HOLD);
    chk("dip released", 1'b1, reset_n_o);
  endtask

  task automatic t_wdog();
    repeat (300) begin
      @(posedge clk_i);
      #1;
      chk("fed no reset", 1'b1, reset_n_o);
    end
    @(posedge clk_i) run <= 1'b0;
    wait_rst(1'b0, WDOG + 10, n);
    chk("starved reset", 1'b0, reset_n_o);
    chk("not early", 1'b1, n >= WDOG - 24);
    wait_rst(1'b1, HOLD + 10, n);
    chk("wdog pulse len", 1'b1, n >= HOLD);
    wait_rst(1'b0, WDOG + 10, n);
    chk("second timeout", 1'b0, reset_n_o);
    chk("restart after pulse", 1'b1, n >= WDOG);
    run <= 1'b1;
    wait_rst(1'b1, HOLD + 10, n);
    // Fed again, so no further timeout may follow
    repeat (100) begin
      @(posedge clk_i);
      #1;
      chk("fed again", 1'b1, reset_n_o);
    end
  endtask

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    manual_reset_n_i = 1'b1;
    supply_low_i = 1'b0;
    early_i = 1'b0;
    pf_i = 1'b0;
    run = 1'b1;
    errors = 0;
    checks = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rst(1'b1, HOLD + 20, n);
    chk("startup release", 1'b1, reset_n_o);
    t_flags();
    t_manual();
    t_supply();
    t_wdog();
    test_done();
  end

  // Scenarios need about 700 cycles, so this leaves ample margin
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    test_done();
  end
endmodule
